/* File: core/ep_ctrl_consts.vh */
// Register map, field positions and reset values of the endpoint control block
`ifndef EP_CTRL_CONSTS_VH
`define EP_CTRL_CONSTS_VH
`define ADDR_W 8
`define OFF_TXCSR 8'h00
`define OFF_RXADDR 8'h04
`define OFF_STATUS 8'h08
`define OFF_LOAD 8'h0c
`define B_AUTOARM 31
`define B_ISO 30
`define B_DIR 29
`define B_DMAEN 28
`define B_FRCTGL 27
`define B_DMAMD 26
`define B_TGLWEN 25
`define B_TGL 24
`define B_TXRDY 16
`define F_MAXP_HI 10
`define F_MAXP_LO 0
`define MAXP_W 11
`define F_HUBPRT_HI 30
`define F_HUBPRT_LO 24
`define B_MULTT 23
`define F_HUBADD_HI 22
`define F_HUBADD_LO 16
`define F_FADDR_HI 6
`define F_FADDR_LO 0
`define RXADDR_MASK 32'h7fff007f
`define TXCSR_WMASK 32'hff0107ff
`define RST_WORD 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ONE_MAXP 11'h001
`define ZERO_MAXP 11'h000
`endif

/* File: core/tx_load_counter.v */
// Counts bytes loaded into the transmit FIFO and flags a full-size packet
`timescale 1ns/10ps
`include "ep_ctrl_consts.vh"
module tx_load_counter
(
   input wire clock,
   input wire rst_b,
   input wire loadByte,
   input wire clearCount,
   input wire [`MAXP_W-1:0] maxPacket,
   output reg fullPacket_r,
   output reg [`MAXP_W-1:0] count_r
);
   reg [`MAXP_W-1:0] count_nxt;
   always @*
   begin
      count_nxt = count_r;
      if (clearCount)
         count_nxt = `ZERO_MAXP;
      else if (loadByte)
         count_nxt = count_r + `ONE_MAXP;
   end
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_r <= `ZERO_MAXP;
         fullPacket_r <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         // One pulse exactly when the count first reaches the max size
         fullPacket_r <= loadByte && !clearCount && (maxPacket != `ZERO_MAXP)
            && (count_nxt == maxPacket);
      end
   end
endmodule

/* File: core/usb_ep_ctrl.v */
// Transmit endpoint control and receive target addressing behind AXI4-Lite
// Summary of operation
// - Auto-arm sets packet-ready on full-size packet
// - Device mode: iso bit selects isochronous
// - Iso bit ignored, reads zero in host
// - Direction bit on a shared FIFO: one transmit, zero receive
// - DMA requests only while enable set
// - Forced toggle flips toggle, drops packet
// - Mode bit picks DMA request mode
// - Host read of toggle shows state
// - Toggle written only with write enable
// - Seven-bit hub port number field
// - Translator count bit: multiple or single
// - Seven-bit hub address field
// - Seven-bit target function address field
// - Unimplemented address bits read zero
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "ep_ctrl_consts.vh"
module usb_ep_ctrl
(
   input wire clock,
   input wire rst_b,
   input wire [`ADDR_W-1:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [`ADDR_W-1:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   input wire hostMode,
   input wire sharedFifo,
   input wire fifoLoadByte,
   input wire packetSent,
   input wire ackReceived,
   input wire dmaTrigger,
   output reg txPacketReady_r,
   output reg isoSelect_r,
   output reg txDirection_r,
   output reg dmaRequest_r,
   output reg dmaModeOne_r,
   output reg dropPacket_r,
   output reg dataToggle_r,
   output reg [6:0] hubPort_r,
   output reg multiTranslator_r,
   output reg [6:0] hubAddress_r,
   output reg [6:0] functionAddress_r
);
   ////////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge, used for both registers
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   // Register hit test, shared by the write strobes and the response code
   function hitReg;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] off;
      begin
         hitReg = (a == off);
      end
   endfunction

   reg autoArm_r;
   reg isoBit_r;
   reg dirBit_r;
   reg dmaEn_r;
   reg dmaMd_r;
   reg tglWen_r;
   reg [`MAXP_W-1:0] maxPacket_r;
   reg [31:0] rxAddr_r;
   reg [`ADDR_W-1:0] wAddr_r;
   reg [31:0] wData_r;
   reg [3:0] wStrb_r;
   reg haveAw_r;
   reg haveW_r;
   wire fullPacket;
   wire [`MAXP_W-1:0] loadCount;
   wire doWrite;
   reg [31:0] txcsrView;
   wire [31:0] wMerged;
   wire forceToggle;
   wire loadClear;
   wire [31:0] rxMerged;
   wire txcsrWrite;
   wire rxaddrWrite;
   wire toggleWrite;
   wire readyWrite;
   reg [31:0] readWord;
   reg [1:0] readResp;

   assign doWrite = haveAw_r && haveW_r && !bvalid;
   assign wMerged = merge(txcsrView, wData_r, wStrb_r);
   assign rxMerged = merge(rxAddr_r, wData_r, wStrb_r);
   // The force, toggle and ready strobes are each qualified by their own byte lane so a partial write leaves the rest
   assign txcsrWrite = doWrite && hitReg(wAddr_r, `OFF_TXCSR);
   assign rxaddrWrite = doWrite && hitReg(wAddr_r, `OFF_RXADDR);
   assign forceToggle = txcsrWrite && wStrb_r[3] && wData_r[`B_FRCTGL];
   assign toggleWrite = txcsrWrite && wStrb_r[3] && wData_r[`B_TGLWEN];
   assign readyWrite = txcsrWrite && wStrb_r[2] && wData_r[`B_TXRDY];
   assign loadClear = forceToggle || packetSent;

   // Read view of the control word; the forced-toggle bit is self-clearing and reads zero
   always @*
   begin
      txcsrView = `RST_WORD;
      txcsrView[`B_AUTOARM] = autoArm_r;
      txcsrView[`B_ISO] = isoBit_r & !hostMode;
      txcsrView[`B_DIR] = dirBit_r;
      txcsrView[`B_DMAEN] = dmaEn_r;
      txcsrView[`B_DMAMD] = dmaMd_r;
      txcsrView[`B_TGLWEN] = tglWen_r;
      txcsrView[`B_TGL] = dataToggle_r;
      txcsrView[`B_TXRDY] = txPacketReady_r;
      txcsrView[`F_MAXP_HI:`F_MAXP_LO] = maxPacket_r;
   end

   tx_load_counter loadCounter
   (
      .clock(clock),
      .rst_b(rst_b),
      .loadByte(fifoLoadByte),
      .clearCount(loadClear),
      .maxPacket(maxPacket_r),
      .fullPacket_r(fullPacket),
      .count_r(loadCount)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         haveAw_r <= 1'b0;
         haveW_r <= 1'b0;
         wAddr_r <= {`ADDR_W{1'b0}};
         wData_r <= `RST_WORD;
         wStrb_r <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            wAddr_r <= awaddr;
            haveAw_r <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wData_r <= wdata;
            wStrb_r <= wstrb;
            haveW_r <= 1'b1;
            wready <= 1'b0;
         end
         if (doWrite)
         begin
            bvalid <= 1'b1;
            haveAw_r <= 1'b0;
            haveW_r <= 1'b0;
            if (hitReg(wAddr_r, `OFF_TXCSR) || hitReg(wAddr_r, `OFF_RXADDR))
               bresp <= `RESP_OKAY;
            else
               bresp <= `RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control fields
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         autoArm_r <= 1'b0;
         isoBit_r <= 1'b0;
         dirBit_r <= 1'b0;
         dmaEn_r <= 1'b0;
         dmaMd_r <= 1'b0;
         tglWen_r <= 1'b0;
         maxPacket_r <= `ZERO_MAXP;
         dropPacket_r <= 1'b0;
         rxAddr_r <= `RST_WORD;
      end
      else
      begin
         dropPacket_r <= forceToggle;
         if (txcsrWrite)
         begin
            autoArm_r <= wMerged[`B_AUTOARM];
            if (!hostMode)
               isoBit_r <= wMerged[`B_ISO];
            dirBit_r <= wMerged[`B_DIR];
            dmaEn_r <= wMerged[`B_DMAEN];
            dmaMd_r <= wMerged[`B_DMAMD];
            tglWen_r <= wMerged[`B_TGLWEN];
            maxPacket_r <= wMerged[`F_MAXP_HI:`F_MAXP_LO];
         end
         // Merged onto its own old value so unstrobed lanes survive
         if (rxaddrWrite)
            rxAddr_r <= rxMerged & `RXADDR_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data toggle: a forced flip wins over everything; an acknowledged packet wins over a written software value in the same cycle
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         dataToggle_r <= 1'b0;
      else if (forceToggle)
         dataToggle_r <= !dataToggle_r;
      else if (packetSent && ackReceived)
         dataToggle_r <= !dataToggle_r;
      else if (toggleWrite)
         dataToggle_r <= wData_r[`B_TGL];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Packet-ready flag: an automatic set wins over a clear in the same cycle
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         txPacketReady_r <= 1'b0;
      else if (autoArm_r && fullPacket)
         txPacketReady_r <= 1'b1;
      else if (loadClear)
         txPacketReady_r <= 1'b0;
      else if (readyWrite)
         txPacketReady_r <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs to the endpoint engine
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         isoSelect_r <= 1'b0;
         txDirection_r <= 1'b0;
         dmaRequest_r <= 1'b0;
         dmaModeOne_r <= 1'b0;
         hubPort_r <= 7'h00;
         multiTranslator_r <= 1'b0;
         hubAddress_r <= 7'h00;
         functionAddress_r <= 7'h00;
      end
      else
      begin
         isoSelect_r <= isoBit_r & !hostMode;
         // Direction only meaningful on a shared FIFO; otherwise fixed transmit
         txDirection_r <= sharedFifo ? dirBit_r : 1'b1;
         dmaRequest_r <= dmaEn_r && dmaTrigger;
         dmaModeOne_r <= dmaMd_r;
         hubPort_r <= rxAddr_r[`F_HUBPRT_HI:`F_HUBPRT_LO];
         multiTranslator_r <= rxAddr_r[`B_MULTT];
         hubAddress_r <= rxAddr_r[`F_HUBADD_HI:`F_HUBADD_LO];
         functionAddress_r <= rxAddr_r[`F_FADDR_HI:`F_FADDR_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read word selection; unmapped words read zero and answer with an error
   always @*
   begin
      readWord = `RST_WORD;
      readResp = `RESP_OKAY;
      case (araddr)
         `OFF_TXCSR: readWord = txcsrView;
         `OFF_RXADDR: readWord = rxAddr_r;
         `OFF_STATUS: readWord = {31'h0, hostMode};
         `OFF_LOAD: readWord = {21'h0, loadCount};
         default: readResp = `RESP_SLVERR;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel: one cycle to rvalid; arready stays low until the data is taken
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= `RST_WORD;
         rresp <= `RESP_OKAY;
      end
      else
      begin
         if (arvalid && arready)
         begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= readResp;
         end
         else if (rvalid && rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule

/* File: tb/usb_ep_ctrl_monitor.sv */
// Checker on the endpoint control block ports
`timescale 1ns/10ps
module usb_ep_ctrl_monitor
(
   input wire clock,
   input wire rst_b,
   input wire wvalid,
   input wire hostMode,
   input wire sharedFifo,
   input wire fifoLoadByte,
   input wire packetSent,
   input wire dmaTrigger,
   input wire txPacketReady_r,
   input wire isoSelect_r,
   input wire txDirection_r,
   input wire dmaRequest_r,
   input wire dmaModeOne_r,
   input wire dropPacket_r,
   input wire dataToggle_r,
   input wire [6:0] hubPort_r,
   input wire [6:0] functionAddress_r
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   AST_ISO_HOST: assert property (hostMode [*2] |=> !isoSelect_r)
      else $error("iso select set in host mode");
   AST_DIR_FIXED: assert property (!sharedFifo [*2] |=> txDirection_r)
      else $error("direction not transmit on own fifo");
   AST_DMA_GATE: assert property (dmaRequest_r |-> $past(dmaTrigger))
      else $error("dma request without trigger");
   AST_DROP_PULSE: assert property ($rose(dropPacket_r) |=> !dropPacket_r)
      else $error("drop pulse too long");
   // Toggle moves only on a register write or a sent packet
   AST_TGL_CAUSE: assert property ($changed(dataToggle_r) |->
      $past(wvalid) || $past(wvalid, 2) || $past(packetSent) || $past(packetSent, 2))
      else $error("toggle changed without cause");
   // Field outputs sit one register behind the stored word, so the cause is three back
   AST_ADDR_CAUSE: assert property ($changed({hubPort_r, functionAddress_r}) |->
      $past(wvalid, 2) || $past(wvalid, 3))
      else $error("address field changed without write");
   AST_PKT_CAUSE: assert property ($rose(txPacketReady_r) |->
      $past(fifoLoadByte) || $past(fifoLoadByte, 2) || $past(wvalid) || $past(wvalid, 2))
      else $error("packet ready set without cause");
   AST_MODE_CAUSE: assert property ($changed(dmaModeOne_r) |->
      $past(wvalid, 2) || $past(wvalid, 3))
      else $error("dma mode changed without write");
endmodule
////////////////////////////////////////
bind usb_ep_ctrl usb_ep_ctrl_monitor u_usb_ep_ctrl_monitor (.clock(clock), .rst_b(rst_b),
   .wvalid(wvalid), .hostMode(hostMode), .sharedFifo(sharedFifo),
   .fifoLoadByte(fifoLoadByte), .packetSent(packetSent), .dmaTrigger(dmaTrigger),
   .txPacketReady_r(txPacketReady_r), .isoSelect_r(isoSelect_r),
   .txDirection_r(txDirection_r), .dmaRequest_r(dmaRequest_r), .dmaModeOne_r(dmaModeOne_r),
   .dropPacket_r(dropPacket_r), .dataToggle_r(dataToggle_r), .hubPort_r(hubPort_r),
   .functionAddress_r(functionAddress_r));

/* File: tb/usb_peer_model.sv */
// Behavioural USB peer: loads FIFO bytes and completes packets
`timescale 1ns/10ps
module usb_peer_model
(
   input wire clock,
   output reg fifoLoadByte,
   output reg packetSent,
   output reg ackReceived
);
   initial
   begin
      fifoLoadByte = 1'b0;
      packetSent = 1'b0;
      ackReceived = 1'b0;
   end
   // A gap between bytes mimics a slow loader
   task load(input integer n, input integer gap);
      integer i;
      for (i = 0; i < n; i = i + 1)
      begin
         @(posedge clock) fifoLoadByte <= 1'b1;
         @(posedge clock) fifoLoadByte <= 1'b0;
         repeat (gap) @(posedge clock);
      end
   endtask
   task send(input ack);
      begin
         @(posedge clock) packetSent <= 1'b1;
         ackReceived <= ack;
         @(posedge clock) packetSent <= 1'b0;
         ackReceived <= 1'b0;
      end
   endtask
endmodule

/* File: tb/usb_ep_ctrl_tb_top.sv */
// Self-checking bench for the endpoint control block
`timescale 1ns/10ps
`include "ep_ctrl_consts.vh"
module usb_ep_ctrl_tb_top;
   reg clock = 1'b0;
   reg rst_b = 1'b0;
   reg [7:0] awaddr = 8'h00;
   reg [7:0] araddr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg [3:0] wstrb = 4'hf, strb = 4'hf;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg hostMode = 1'b0, sharedFifo = 1'b0, dmaTrigger = 1'b0, seenDrop = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, fifoLoadByte, packetSent, ackReceived;
   wire txPacketReady_r, isoSelect_r, txDirection_r, dmaRequest_r, dmaModeOne_r;
   wire dropPacket_r, dataToggle_r, multiTranslator_r;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [6:0] hubPort_r, hubAddress_r, functionAddress_r;
   reg [31:0] rv, resp;
   integer fails = 0;
   integer nChecks = 0;
   always #5 clock = ~clock;
   always @(posedge clock) if (dropPacket_r === 1'b1) seenDrop <= 1'b1;
   usb_ep_ctrl u_usb_ep_ctrl (.clock(clock), .rst_b(rst_b), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .hostMode(hostMode), .sharedFifo(sharedFifo),
      .fifoLoadByte(fifoLoadByte), .packetSent(packetSent), .ackReceived(ackReceived),
      .dmaTrigger(dmaTrigger), .txPacketReady_r(txPacketReady_r), .isoSelect_r(isoSelect_r),
      .txDirection_r(txDirection_r), .dmaRequest_r(dmaRequest_r),
      .dmaModeOne_r(dmaModeOne_r), .dropPacket_r(dropPacket_r), .dataToggle_r(dataToggle_r),
      .hubPort_r(hubPort_r), .multiTranslator_r(multiTranslator_r),
      .hubAddress_r(hubAddress_r), .functionAddress_r(functionAddress_r));
   usb_peer_model u_usb_peer_model (.clock(clock), .fifoLoadByte(fifoLoadByte),
      .packetSent(packetSent), .ackReceived(ackReceived));
   ////////////////////////////////////////
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         nChecks = nChecks + 1;
         if (seen !== exp)
         begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clock);
         awaddr <= a;
         wdata <= d;
         wstrb <= strb;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do
         begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end
         while (bvalid !== 1'b1);
         resp = 32'(bresp);
         bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge clock);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do
         begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
         end
         while (rvalid !== 1'b1);
         rv = rdata;
         resp = 32'(rresp);
         rready <= 1'b0;
      end
   endtask
   task settle;
      begin
         repeat (3) @(posedge clock);
         #1;
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", nChecks, fails);
         if (fails == 0 && nChecks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial
   begin
      #300000;
      fails = fails + 1;
      stop_test;
   end
   ////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      rd(`OFF_RXADDR);
      chk("rxaddr reset", rv, 32'h0);
      wr(`OFF_RXADDR, 32'hffffffff);
      rd(`OFF_RXADDR);
      chk("rxaddr ones", rv, 32'h7fff007f);
      wr(`OFF_RXADDR, 32'h55b30042);
      settle;
      chk("rx fields", 32'({hubPort_r, multiTranslator_r, hubAddress_r, functionAddress_r}),
         32'h2ad9c2);
      strb = 4'h1;
      wr(`OFF_RXADDR, 32'hffffff13);
      strb = 4'hf;
      rd(`OFF_RXADDR);
      chk("rx byte lane", rv, 32'h55b30013);
      wr(8'h10, 32'h1);
      chk("bad wr resp", resp, 32'h2);
      rd(8'h10);
      chk("bad rd", {resp[1:0], rv[29:0]}, 32'h80000000);
      $display("address test done");
      wr(`OFF_TXCSR, 32'h40000000);
      settle;
      chk("iso dev", 32'({isoSelect_r, txDirection_r}), 32'h3);
      @(posedge clock) sharedFifo <= 1'b1;
      settle;
      chk("dir rx", 32'(txDirection_r), 32'h0);
      wr(`OFF_TXCSR, 32'h20000000);
      settle;
      chk("iso off dir tx", 32'({isoSelect_r, txDirection_r}), 32'h1);
      wr(`OFF_TXCSR, 32'h60000000);
      @(posedge clock) hostMode <= 1'b1;
      rd(`OFF_STATUS);
      chk("status host", rv, 32'h1);
      wr(`OFF_TXCSR, 32'h41000000);
      settle;
      chk("iso host tgl", 32'({isoSelect_r, dataToggle_r}), 32'h0);
      rd(`OFF_TXCSR);
      chk("iso rd", 32'(rv[30]), 32'h0);
      wr(`OFF_TXCSR, 32'h03000000);
      u_usb_peer_model.send(1'b0);
      settle;
      rd(`OFF_TXCSR);
      chk("tgl rd", 32'(rv[24]), 32'h1);
      wr(`OFF_TXCSR, 32'h08000000);
      settle;
      chk("forced tgl", 32'({dataToggle_r, seenDrop}), 32'h1);
      u_usb_peer_model.send(1'b1);
      rd(`OFF_TXCSR);
      chk("acked tgl", 32'(rv[24]), 32'h1);
      $display("mode test done");
      @(posedge clock) dmaTrigger <= 1'b1;
      wr(`OFF_TXCSR, 32'h14000000);
      settle;
      chk("dma on", 32'({dmaRequest_r, dmaModeOne_r}), 32'h3);
      wr(`OFF_TXCSR, 32'h04000000);
      settle;
      chk("dma off", 32'({dmaRequest_r, dmaModeOne_r}), 32'h1);
      wr(`OFF_TXCSR, 32'h0);
      settle;
      chk("mode0", 32'(dmaModeOne_r), 32'h0);
      $display("dma test done");
      wr(`OFF_TXCSR, 32'h80000004);
      u_usb_peer_model.load(3, 1);
      settle;
      chk("short pkt", 32'(txPacketReady_r), 32'h0);
      rd(`OFF_LOAD);
      chk("load count", rv, 32'h3);
      wr(`OFF_TXCSR, 32'h80010004);
      settle;
      chk("sw ready", 32'(txPacketReady_r), 32'h1);
      @(posedge clock) rst_b <= 1'b0;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      rd(`OFF_RXADDR);
      chk("rxaddr reset2", rv, 32'h0);
      wr(`OFF_TXCSR, 32'h00000004);
      u_usb_peer_model.load(4, 0);
      settle;
      chk("no auto", 32'(txPacketReady_r), 32'h0);
      u_usb_peer_model.send(1'b0);
      wr(`OFF_TXCSR, 32'h80000004);
      u_usb_peer_model.load(4, 0);
      settle;
      chk("auto ready", 32'(txPacketReady_r), 32'h1);
      $display("packet test done");
      stop_test;
   end
endmodule
